/* rtl/dac_input_mux.sv */
// Purpose: dac side input latches, interleave mux and divider control
// Assumes: CORE_CLK_IN is the 2x update clock; link on the same clock
// Notes: a two entry buffer feeds the input latches one pair per 1x tick
`timescale 1ns/1ps
// Functional notes
// - multiplier on, both ports captured each tick
// - same edge, old second port to output
// - half period later, first port to output
// - update instants made internally, duty independent
// - supply strap low disables multiplier, straps mux
// - source clocks at full update rate
// - straps 00 both, 01 first, 10 second
// - disabled interleave divides 2x clock by two
// - delayed 1x clock shown on lock pin
// - source changes data on 1x-aligned edge
// - reset pulse forces lock pin 1x high
// - low next edge, high plus load after
// - reset release away from clock edge
// - single port loads selected latch only
// - single port output one clock later
// - unsigned code, complement is 1023 minus code
// - multiplier on, reset ignored, lock pin locked
// - ten bit straight binary, msb highest pin
// - multiplier on, straps pick prescale 1..8
module dac_input_mux #(
   parameter int LOCK_CYCLES = dac_mux_pkg::LOCK_BASE_CYCLES
) (
   input wire logic CORE_CLK_IN,
   input wire logic RST_IN,
   input wire logic CE_IN,
   dac_link_if.dac LINK,
   output logic [dac_mux_pkg::CODE_W-1:0] CODE_OUT,
   output logic [dac_mux_pkg::CODE_W-1:0] CODE_N_OUT,
   output logic [3:0] PRESCALE_OUT,
   output logic MODE_INVALID_OUT,
   output logic UNDERRUN_OUT
);
   import dac_mux_pkg::*;

   //----------------------------------------------------------------
   // mode decode
   //----------------------------------------------------------------
   logic mult_on;
   input_mode_t mode;
   logic [1:0] straps;
   assign mult_on = LINK.multiplier_supply_strap;
   assign straps = {LINK.range_strap_high, LINK.range_strap_low};
   assign mode = input_mode_t'(straps);

   // complement of the code; used for the reset value and every update
   function automatic logic [CODE_W-1:0] complement(input logic [CODE_W-1:0] c);
      complement = CODE_MAX - c;
   endfunction

   //----------------------------------------------------------------
   // 1x phase generator
   //----------------------------------------------------------------
   // half_clk high means the next edge is the second half of a 1x period;
   // a low half_clk marks the edge that loads the input latches
   logic half_clk;
   logic load_tick;
   logic mid_tick;
   logic sync_active;
   assign sync_active = ~mult_on & LINK.sync_reset;
   assign load_tick = ~half_clk & ~sync_active;
   assign mid_tick = half_clk & ~sync_active;

   // free toggle gives fixed half period spacing whatever the input duty
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         half_clk <= 1'b1;
      end else if (CE_IN) begin
         if (sync_active) begin
            half_clk <= 1'b1;
         end else begin
            half_clk <= ~half_clk;
         end
      end
   end

   //----------------------------------------------------------------
   // two entry word buffer
   //----------------------------------------------------------------
   logic [2*CODE_W-1:0] buf_mem [BUF_DEPTH];
   logic buf_wr_ptr;
   logic buf_rd_ptr;
   logic [1:0] buf_count;
   logic buf_push;
   logic buf_pop;
   logic buf_has;
   logic consume;
   logic [2*CODE_W-1:0] buf_head;
   assign buf_has = (buf_count != 2'h0);
   assign buf_head = buf_mem[buf_rd_ptr];
   // only a load edge drains, so a slow divider really fills the buffer
   assign consume = load_tick & (mult_on | (mode != MODE_INVALID));
   assign buf_pop = consume & buf_has;
   assign buf_push = LINK.word_valid & LINK.word_ready;

   always_ff @(posedge CORE_CLK_IN) begin
      if (CE_IN && buf_push) begin
         buf_mem[buf_wr_ptr] <= {LINK.port_b, LINK.port_a};
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         buf_wr_ptr <= 1'b0;
         buf_rd_ptr <= 1'b0;
         buf_count <= 2'h0;
      end else if (CE_IN) begin
         if (buf_push) begin
            buf_wr_ptr <= ~buf_wr_ptr;
         end
         if (buf_pop) begin
            buf_rd_ptr <= ~buf_rd_ptr;
         end
         buf_count <= buf_count + {1'b0, buf_push} - {1'b0, buf_pop};
      end
   end

   // ready is registered: it looks ahead at the count after this edge
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         LINK.word_ready <= 1'b0;
      end else if (CE_IN) begin
         LINK.word_ready <= (buf_count + {1'b0, buf_push} - {1'b0, buf_pop})
            < 2'(BUF_DEPTH);
      end
   end

   //----------------------------------------------------------------
   // input latches
   //----------------------------------------------------------------
   logic [CODE_W-1:0] latch_a;
   logic [CODE_W-1:0] latch_b;
   logic load_a;
   logic load_b;
   assign load_a = buf_pop & (mult_on | (mode != MODE_PORT_B));
   assign load_b = buf_pop & (mult_on | (mode != MODE_PORT_A));

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         latch_a <= CODE_RESET;
         latch_b <= CODE_RESET;
      end else if (CE_IN) begin
         if (load_a) begin
            latch_a <= buf_head[CODE_W-1:0];
         end
         if (load_b) begin
            latch_b <= buf_head[2*CODE_W-1:CODE_W];
         end
      end
   end

   //----------------------------------------------------------------
   // output latch
   //----------------------------------------------------------------
   // the output takes the latch contents from before this edge's load,
   // which gives the one tick of double buffering
   logic [CODE_W-1:0] next_code;
   logic next_update;
   always_comb begin
      next_code = CODE_OUT;
      next_update = 1'b0;
      if (mult_on || mode == MODE_INTERLEAVE) begin
         if (load_tick) begin
            next_code = latch_b;
            next_update = 1'b1;
         end else if (mid_tick) begin
            next_code = latch_a;
            next_update = 1'b1;
         end
      end else if (load_tick) begin
         unique case (mode)
            MODE_PORT_A: begin
               next_code = latch_a;
               next_update = 1'b1;
            end
            MODE_PORT_B: begin
               next_code = latch_b;
               next_update = 1'b1;
            end
            default: begin
               next_update = 1'b0; // invalid straps hold the output
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         CODE_OUT <= CODE_RESET;
         CODE_N_OUT <= complement(CODE_RESET);
      end else if (CE_IN && next_update) begin
         CODE_OUT <= next_code;
         CODE_N_OUT <= complement(next_code);
      end
   end

   //----------------------------------------------------------------
   // lock pin, prescaler and status
   //----------------------------------------------------------------
   logic [LOCK_CNT_W-1:0] lock_cnt;
   logic [LOCK_CNT_W-1:0] lock_target;
   logic [1:0] range_q;
   // lower input ranges take proportionally longer to settle
   assign lock_target = LOCK_CNT_W'(LOCK_CYCLES) << straps;

   // a strap change while active restarts the lock count
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         lock_cnt <= '0;
         range_q <= RANGE_RANGE_STRAP_HIGH;
      end else if (CE_IN) begin
         range_q <= straps;
         if (!mult_on || range_q != straps) begin
            lock_cnt <= '0;
         end else if (lock_cnt != lock_target) begin
            lock_cnt <= lock_cnt + 1'b1;
         end
      end
   end

   // disabled: one flop behind half_clk stands for the pin delay
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         LINK.lock_or_half_clock_out <= 1'b0;
      end else if (CE_IN) begin
         if (mult_on) begin
            LINK.lock_or_half_clock_out <= (lock_cnt == lock_target);
         end else begin
            LINK.lock_or_half_clock_out <= ~half_clk | sync_active;
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         PRESCALE_OUT <= PRESCALE_ONE;
         MODE_INVALID_OUT <= 1'b0;
         UNDERRUN_OUT <= 1'b0;
      end else if (CE_IN) begin
         PRESCALE_OUT <= mult_on ? (PRESCALE_ONE << straps) : PRESCALE_ONE;
         MODE_INVALID_OUT <= ~mult_on & (mode == MODE_INVALID);
         UNDERRUN_OUT <= consume & ~buf_has;
      end
   end
endmodule

/* rtl/dac_mux_pkg.sv */
// Purpose: shared constants and types for the dual port dac input mux
// Assumes: one clock that stands for the 2x output update clock
// Notes: both ends and the link interface import this package
package dac_mux_pkg;
   localparam int CODE_W = 10;
   localparam logic [CODE_W-1:0] CODE_MAX = 10'h3FF;
   localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
   // strap pair {high, low} with the multiplier disabled
   typedef enum logic [1:0] {
      MODE_INTERLEAVE = 2'h0,
      MODE_PORT_A = 2'h1,
      MODE_PORT_B = 2'h2,
      MODE_INVALID = 2'h3
   } input_mode_t;
   // range prescaler shift per strap code with the multiplier active
   localparam logic [1:0] RANGE_RANGE_STRAP_HIGH = 2'h0;
   localparam logic [3:0] PRESCALE_ONE = 4'h1;
   // lock detector settle time, in 2x clock cycles before prescaling
   localparam int LOCK_BASE_CYCLES = 16;
   localparam int LOCK_CNT_W = 8;
   // length of the divider alignment pulse from the source
   localparam int SYNC_PULSE_CYCLES = 2;
   localparam int BUF_DEPTH = 2;
endpackage

/* rtl/dac_link_if.sv */
// Purpose: pin level link between the sample source and the dac mux
// Assumes: both ends run on the same clock
// Notes: words move with valid and ready; straps are plain levels
`timescale 1ns/1ps
interface dac_link_if;
   import dac_mux_pkg::*;
   logic [CODE_W-1:0] port_a; // data_msb is bit 9, data_lsb bit 0
   logic [CODE_W-1:0] port_b;
   logic word_valid;
   logic word_ready;
   logic multiplier_supply_strap;
   logic range_strap_high;
   logic range_strap_low;
   logic sync_reset;
   logic lock_or_half_clock_out;
   modport dac (
      input port_a, port_b, word_valid, multiplier_supply_strap,
      input range_strap_high, range_strap_low, sync_reset,
      output word_ready, lock_or_half_clock_out
   );
   modport source (
      output port_a, port_b, word_valid, multiplier_supply_strap,
      output range_strap_high, range_strap_low, sync_reset,
      input word_ready, lock_or_half_clock_out
   );
endinterface

/* rtl/dac_sample_source.sv */
// Purpose: sample source end that drives words, straps and the sync pulse
// Assumes: same clock as the dac end
// Notes: the lock pin is treated as foreign and passes three flops
`timescale 1ns/1ps
module dac_sample_source (
   input wire logic CORE_CLK_IN,
   input wire logic RST_IN,
   input wire logic CE_IN,
   input wire logic [dac_mux_pkg::CODE_W-1:0] PORT_A_IN,
   input wire logic [dac_mux_pkg::CODE_W-1:0] PORT_B_IN,
   input wire logic VALID_IN,
   input wire logic MULT_EN_IN,
   input wire logic [1:0] MODE_IN,
   input wire logic SYNC_REQ_IN,
   output logic READY_OUT,
   output logic LOCK_OUT,
   dac_link_if.source LINK
);
   import dac_mux_pkg::*;

   //----------------------------------------------------------------
   // word holding stage
   //----------------------------------------------------------------
   logic next_valid;
   logic take;
   assign take = VALID_IN & READY_OUT;
   assign next_valid = take | (LINK.word_valid & ~LINK.word_ready);

   // one word in flight; ready is registered so it trails by a cycle
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         LINK.word_valid <= 1'b0;
         LINK.port_a <= CODE_RESET;
         LINK.port_b <= CODE_RESET;
         READY_OUT <= 1'b0;
      end else if (CE_IN) begin
         LINK.word_valid <= next_valid;
         READY_OUT <= ~next_valid;
         if (take) begin
            LINK.port_a <= PORT_A_IN;
            LINK.port_b <= PORT_B_IN;
         end
      end
   end

   //----------------------------------------------------------------
   // straps and sync pulse
   //----------------------------------------------------------------
   localparam int PULSE_W = $clog2(SYNC_PULSE_CYCLES + 1);
   logic [PULSE_W-1:0] pulse_cnt;
   logic strap_change;
   assign strap_change = (MULT_EN_IN != LINK.multiplier_supply_strap)
      | (MODE_IN != {LINK.range_strap_high, LINK.range_strap_low});

   // straps move only here, and any move or request with the multiplier off resyncs the divider
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         LINK.multiplier_supply_strap <= 1'b1;
         LINK.range_strap_high <= 1'b0;
         LINK.range_strap_low <= 1'b0;
         LINK.sync_reset <= 1'b0;
         pulse_cnt <= '0;
      end else if (CE_IN) begin
         LINK.multiplier_supply_strap <= MULT_EN_IN;
         {LINK.range_strap_high, LINK.range_strap_low} <= MODE_IN;
         if ((SYNC_REQ_IN || strap_change) && !MULT_EN_IN) begin
            pulse_cnt <= PULSE_W'(SYNC_PULSE_CYCLES);
         end else if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - 1'b1;
         end
         // released on a clock edge, so away from the guard window
         LINK.sync_reset <= ~MULT_EN_IN & (pulse_cnt != '0);
      end
   end

   //----------------------------------------------------------------
   // lock pin synchroniser
   //----------------------------------------------------------------
   logic lock_meta;
   logic lock_sync;
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         lock_meta <= 1'b0;
         lock_sync <= 1'b0;
         LOCK_OUT <= 1'b0;
      end else if (CE_IN) begin
         lock_meta <= LINK.lock_or_half_clock_out;
         lock_sync <= lock_meta;
         LOCK_OUT <= lock_sync;
      end
   end
endmodule

/* bench/dac_link_chk.sv */
// Purpose: link checker for the dac mux and its sample source
// Assumes: one clock, synchronous reset active high
// Notes: sees only the link wires between the two ends
`timescale 1ns/1ps
module dac_link_chk
   import dac_mux_pkg::*;
#(
   parameter int LOCK_CYCLES = LOCK_BASE_CYCLES
) (
   input wire logic CORE_CLK_IN,
   input wire logic RST_IN,
   input wire logic [dac_mux_pkg::CODE_W-1:0] port_a,
   input wire logic [dac_mux_pkg::CODE_W-1:0] port_b,
   input wire logic word_valid,
   input wire logic word_ready,
   input wire logic multiplier_supply_strap,
   input wire logic range_strap_high,
   input wire logic range_strap_low,
   input wire logic sync_reset,
   input wire logic lock_or_half_clock_out
);
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (RST_IN);
   // --------------------------------------------------
   // cycles with multiplier on and straps at 00
   // --------------------------------------------------
   logic [7:0] calm;
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN || !multiplier_supply_strap || range_strap_high || range_strap_low) begin
         calm <= 8'h00;
      end else if (calm != 8'hFF) begin
         calm <= calm + 8'h01;
      end
   end
   a_word_holds:
   assert property (word_valid && !word_ready |=> word_valid && $stable(port_a)
      && $stable(port_b)) else $error("word moved before taken");
   a_word_gap:
   assert property (word_valid && word_ready |=> !word_valid) else $error("word not released");
   a_sync_forces_pin:
   assert property (sync_reset && !multiplier_supply_strap |-> ##[1:2] lock_or_half_clock_out)
      else $error("pin not high in sync");
   a_pin_after_sync:
   assert property ($fell(sync_reset) && !multiplier_supply_strap |-> ##[1:2]
      !lock_or_half_clock_out ##1 lock_or_half_clock_out) else $error("pin order wrong");
   a_sync_pulse_len:
   assert property ($rose(sync_reset) |-> sync_reset[*2]) else $error("sync pulse short");
   a_resync_change:
   assert property (!multiplier_supply_strap && ($changed(range_strap_low)
      || $changed(range_strap_high) || $fell(multiplier_supply_strap)) |-> ##[0:8] sync_reset)
      else $error("no resync after strap change");
   a_lock_cleared:
   assert property (multiplier_supply_strap && ($changed(range_strap_low)
      || $changed(range_strap_high)) |-> ##[1:2] !lock_or_half_clock_out)
      else $error("lock kept after change");
   a_lock_in_time:
   assert property (calm > 8'(LOCK_CYCLES + 4) |-> lock_or_half_clock_out)
      else $error("lock late");
   // main traffic seen at least once
   c_word: cover property (word_valid && word_ready);
   c_sync: cover property ($fell(sync_reset));
   c_single: cover property (!multiplier_supply_strap && range_strap_low);
endmodule

/* bench/dual_port_dac_input_mux_tb.sv */
// Purpose: self checking bench for the dac mux and sample source
// Assumes: 20 MHz clock, the two ends face each other on the link
// Notes: lock count shortened to 2 to keep the run short
`timescale 1ns/1ps
module dual_port_dac_input_mux_tb;
   import dac_mux_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [CODE_W-1:0] pa = 10'h000;
   logic [CODE_W-1:0] pb = 10'h000;
   logic valid = 1'b0;
   logic mult_en = 1'b1;
   logic [1:0] mode = 2'h0;
   logic sync_req = 1'b0;
   logic ready, lock, mode_bad;
   logic [CODE_W-1:0] code, code_n;
   logic [3:0] prescale;
   logic underrun;
   logic ce = 1'b1;
   int fails = 0;
   int checks = 0;
   dac_link_if link();
   // --------------------------------------------------
   // the two ends and the link checker
   // --------------------------------------------------
   dac_input_mux #(.LOCK_CYCLES(2)) i_dac_input_mux (.CORE_CLK_IN(clk), .RST_IN(rst),
      .CE_IN(ce), .LINK(link), .CODE_OUT(code), .CODE_N_OUT(code_n),
      .PRESCALE_OUT(prescale), .MODE_INVALID_OUT(mode_bad), .UNDERRUN_OUT(underrun));
   dac_sample_source i_dac_sample_source (.CORE_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
      .PORT_A_IN(pa), .PORT_B_IN(pb), .VALID_IN(valid), .MULT_EN_IN(mult_en),
      .MODE_IN(mode), .SYNC_REQ_IN(sync_req), .READY_OUT(ready), .LOCK_OUT(lock),
      .LINK(link));
   dac_link_chk #(.LOCK_CYCLES(2)) i_dac_link_chk (.CORE_CLK_IN(clk), .RST_IN(rst),
      .port_a(link.port_a), .port_b(link.port_b), .word_valid(link.word_valid),
      .word_ready(link.word_ready), .multiplier_supply_strap(link.multiplier_supply_strap),
      .range_strap_high(link.range_strap_high), .range_strap_low(link.range_strap_low),
      .sync_reset(link.sync_reset), .lock_or_half_clock_out(link.lock_or_half_clock_out));
   // 50 ns period
   always #25 clk = ~clk;
   // --------------------------------------------------
   // compares, waits and the verdict
   // --------------------------------------------------
   task automatic chk_code(input string what, input logic [9:0] e, input logic [9:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk_ctl(input string what, input logic [3:0] e, input logic [3:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic final_report();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // bounded wait: a hang ends the run as a mismatch
   task automatic wait_code(input logic [9:0] e);
      for (int n = 0; n < 40 && code !== e; n++) begin
         @(negedge clk);
      end
      if (code !== e) begin
         chk_code("code wait", e, code);
         final_report();
      end
   endtask
   // word held until an edge sees ready high
   task automatic send_pair(input logic [9:0] a, input logic [9:0] b);
      @(posedge clk);
      pa <= a;
      pb <= b;
      valid <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(negedge clk);
         if (ready === 1'b1) begin
            @(posedge clk);
            valid <= 1'b0;
            return;
         end
      end
      fails++;
      $display("mismatch word ready expected 1 seen 0");
      final_report();
   endtask
   // first port then second port on consecutive updates
   task automatic check_pair(input logic [9:0] a, input logic [9:0] b);
      wait_code(a);
      @(negedge clk);
      chk_code("second port", b, code);
      chk_code("complement", CODE_MAX - b, code_n);
   endtask
   // --------------------------------------------------
   // scenarios
   // --------------------------------------------------
   task automatic t_reset();
      chk_code("code reset", CODE_RESET, code);
      chk_code("complement reset", CODE_MAX, code_n);
      chk_ctl("prescale reset", PRESCALE_ONE, prescale);
      chk_ctl("underrun idle", 4'h1, {3'h0, underrun});
   endtask
   task automatic t_prescale();
      for (int m = 0; m < 5; m++) begin
         @(posedge clk);
         mode <= 2'(m % 4);
         @(negedge clk);
         for (int n = 0; n < 20 && prescale !== (4'h1 << (m % 4)); n++) begin
            @(negedge clk);
         end
         chk_ctl("prescale", 4'h1 << (m % 4), prescale);
      end
      for (int n = 0; n < 200 && lock !== 1'b1; n++) begin
         @(negedge clk);
      end
      chk_ctl("lock", 4'h1, {3'h0, lock});
   endtask
   // back to back pairs, the second from the buffer
   task automatic t_interleave(input logic m, input logic [39:0] v);
      @(posedge clk);
      mult_en <= m;
      mode <= MODE_INTERLEAVE;
      sync_req <= ~m;
      @(posedge clk);
      sync_req <= 1'b0;
      fork
         begin
            send_pair(v[39:30], v[29:20]);
            send_pair(v[19:10], v[9:0]);
         end
         begin
            check_pair(v[39:30], v[29:20]);
            check_pair(v[19:10], v[9:0]);
         end
      join
   endtask
   // only the chosen port reaches the output, then holds
   // keep is the selected latch from before, untouched by the other port's words
   task automatic t_single(input logic [1:0] m, input logic [9:0] a, input logic [9:0] b,
      input logic [9:0] keep);
      @(posedge clk);
      mult_en <= 1'b0;
      mode <= m;
      send_pair(a, b);
      @(negedge clk);
      wait_code(keep);
      wait_code((m == MODE_PORT_A) ? a : b);
      repeat (6) @(negedge clk);
      chk_code("single hold", (m == MODE_PORT_A) ? a : b, code);
   endtask
   // invalid straps flag and never pop the buffer
   task automatic t_invalid();
      @(posedge clk);
      mode <= MODE_INVALID;
      send_pair(10'h111, 10'h222);
      for (int n = 0; n < 20 && mode_bad !== 1'b1; n++) begin
         @(negedge clk);
      end
      chk_ctl("invalid flag", 4'h1, {3'h0, mode_bad});
      repeat (8) @(negedge clk);
      chk_code("invalid hold", 10'h0C3, code);
      chk_ctl("invalid no drain", 4'h0, {3'h0, underrun});
   endtask
   // clock enable low freezes both ends; odd count so a running mux would differ
   task automatic t_freeze();
      logic [9:0] held;
      @(posedge clk);
      ce <= 1'b0;
      @(negedge clk);
      held = code;
      repeat (3) @(negedge clk);
      chk_code("frozen code", held, code);
      @(posedge clk);
      ce <= 1'b1;
      repeat (2) @(negedge clk);
      chk_code("resumed code", CODE_MAX - held, code);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      t_reset();
      t_prescale();
      t_interleave(1'b1, {10'h200, 10'h001, 10'h3FF, 10'h000});
      t_interleave(1'b0, {10'h0F0, 10'h30F, 10'h155, 10'h2AA});
      t_freeze();
      t_single(MODE_PORT_A, 10'h2D2, 10'h12D, 10'h155);
      t_single(MODE_PORT_B, 10'h3C3, 10'h0C3, 10'h2AA);
      t_invalid();
      final_report();
   end
   // watchdog on the whole run
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      $display("mismatch run limit expected done seen running");
      final_report();
   end
endmodule
